// ---- verilog/prs_defs.vh ----
`ifndef PRS_DEFS_VH
`define PRS_DEFS_VH

// Register offsets in the standard and extended space.
`define PRS_OFS_BASIC_MODE 16'h0000
`define PRS_OFS_INDICATOR 16'h0018
`define PRS_OFS_GLOBAL 16'h001F
// Register offset in the PCS register space.
`define PRS_OFS_PCS_CTRL 16'h1000

// Field positions.
`define PRS_BIT_SOFT_RESET 15
`define PRS_BIT_RESTART 14
`define PRS_IND_FIELD_W 4
`define PRS_IND_OFF_BIT 3

// Reset values.
`define PRS_RST_BASIC_MODE 16'h1140
`define PRS_RST_INDICATOR 16'h3210
`define PRS_RST_GLOBAL 16'h0000
`define PRS_RST_PCS_CTRL 16'h2040

// Timing.
`define PRS_CLK_PERIOD_NS 5
`define PRS_PIN_LOW_MIN_NS 1000
`define PRS_STRAP_CYC 16
`define PRS_ACTION_CYC 8

`endif

// ---- verilog/prs_reset_led.v ----
// Notes on behaviour
// (RQ1) Indicator pin functions follow the indicator mode control register.
// (RQ2) Indicator pin levels are sampled at power up or reset, fixing polarity.
// (RQ3) A pin sampled low drives its indicator active high.
// (RQ4) A pin sampled high drives its indicator active low.
// (RQ5) The device resets itself at power up without any external reset.
// (RQ6) An external controller holds the reset pin low at least one microsecond.
// (RQ7) Hardware reset restores all register defaults and re-samples the straps.
// (RQ8) Basic mode control bit 15 resets only the standard registers.
// (RQ9) Global control bit 15 resets all circuits and all registers.
// (RQ10) Global soft reset keeps the latched strap levels.
// (RQ11) Global control bit 14 restarts circuits, registers untouched.
// (RQ12) PCS control bit 15 resets PCS-space and autoneg-space registers.
// (RQ13) A PCS-space reset is followed by a standard-register soft reset.
// (RQ14) Software leaves unmapped offsets alone; they read zero, writes ignored.
// (RQ15) Each reset or restart bit clears itself when its action ends.
`timescale 1ns/1ps
`include "prs_defs.vh"

module prs_reset_led #(
  parameter STRAP_CYC = `PRS_STRAP_CYC,
  parameter ACTION_CYC = `PRS_ACTION_CYC
) (
  // Clock and power-on reset.
  input wire mclk,
  input wire srst,
  // Hardware reset pin.
  input wire reset_n_pin,
  // Management register port.
  input wire mgmt_wr,
  input wire mgmt_rd,
  input wire mgmt_pcs_space,
  input wire [15:0] mgmt_addr,
  input wire [15:0] mgmt_wdata,
  output reg [15:0] mgmt_rdata,
  output reg mgmt_rvalid,
  // Dual-purpose indicator and strap pins.
  input wire [3:0] indicator_in,
  output reg [3:0] indicator_out,
  output reg [3:0] indicator_oe,
  // Indicator function sources from the PHY core.
  input wire [7:0] func_src,
  // Reset controls and latched strap levels toward the PHY core.
  output reg dev_hard_rst,
  output reg std_regs_rst,
  output reg global_rst,
  output reg restart,
  output reg pcs_space_rst,
  output reg [3:0] strap_level
);

  localparam [31:0] PIN_CYC32 =
    (`PRS_PIN_LOW_MIN_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS;
  localparam [8:0] PIN_CYC = PIN_CYC32[8:0];
  localparam [31:0] STRAP_LAST32 = STRAP_CYC - 1;
  localparam [31:0] ACTION_LAST32 = ACTION_CYC - 1;
  localparam [7:0] STRAP_LAST = STRAP_LAST32[7:0];
  localparam [7:0] ACTION_LAST = ACTION_LAST32[7:0];

  localparam [2:0] S_HARD = 3'h0;
  localparam [2:0] S_STRAP = 3'h1;
  localparam [2:0] S_IDLE = 3'h2;
  localparam [2:0] S_STD = 3'h3;
  localparam [2:0] S_GLB = 3'h4;
  localparam [2:0] S_RSTRT = 3'h5;
  localparam [2:0] S_PCS = 3'h6;

  reg [4:0] pin_s1;
  reg [4:0] pin_s2;
  reg [4:0] pin_s3;
  reg [4:0] pin_stable;
  reg [8:0] low_cnt;
  reg [2:0] state;
  reg [7:0] cnt;
  reg [15:0] basic_mode_control;
  reg [15:0] indicator_mode_control;
  reg [15:0] global_reset_control;
  reg [15:0] pcs_space_control;
  reg [3:0] next_indicator;
  reg [3:0] field;
  integer i;
  integer j;

  wire pin_hold = ~pin_stable[4] && (low_cnt == PIN_CYC);
  wire act_done = (cnt == ACTION_LAST);
  wire holding = ((state == S_STD) || (state == S_GLB) ||
                  (state == S_PCS)) && !act_done;
  wire wr_ok = mgmt_wr && (state != S_HARD) && (state != S_STRAP) &&
               !holding;
  wire hit_bmc = !mgmt_pcs_space && (mgmt_addr == `PRS_OFS_BASIC_MODE);
  wire hit_ind = !mgmt_pcs_space && (mgmt_addr == `PRS_OFS_INDICATOR);
  wire hit_glb = !mgmt_pcs_space && (mgmt_addr == `PRS_OFS_GLOBAL);
  wire hit_pcs = mgmt_pcs_space && (mgmt_addr == `PRS_OFS_PCS_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Bit 4 is the reset pin, bits 3:0 the strap pins.
  // A glitch shorter than the minimum low time is filtered out.

  always @(posedge mclk) begin
    if (srst) begin
      pin_s1 <= 5'h10;
      pin_s2 <= 5'h10;
      pin_s3 <= 5'h10;
      pin_stable <= 5'h10;
      low_cnt <= 9'h000;
    end else begin
      pin_s1 <= {reset_n_pin, indicator_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (i = 0; i < 5; i = i + 1) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_stable[i] <= pin_s3[i];
        end
      end
      if (pin_stable[4]) begin
        low_cnt <= 9'h000;
      end else if (low_cnt != PIN_CYC) begin
        low_cnt <= low_cnt + 9'h001; // RQ6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer and register file.

  always @(posedge mclk) begin
    if (srst || pin_hold) begin
      state <= S_HARD; // RQ5
      cnt <= 8'h00;
      basic_mode_control <= `PRS_RST_BASIC_MODE; // RQ7
      indicator_mode_control <= `PRS_RST_INDICATOR;
      global_reset_control <= `PRS_RST_GLOBAL;
      pcs_space_control <= `PRS_RST_PCS_CTRL;
      strap_level <= 4'h0;
    end else begin
      case (state)
        S_HARD: begin
          state <= S_STRAP;
          cnt <= 8'h00;
        end
        S_STRAP: begin
          cnt <= cnt + 8'h01;
          if (cnt == STRAP_LAST) begin
            // Pins are undriven here, so the resistor level is seen.
            strap_level <= pin_stable[3:0]; // RQ2 RQ7
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          cnt <= 8'h00;
          if (global_reset_control[`PRS_BIT_SOFT_RESET]) begin
            state <= S_GLB;
          end else if (global_reset_control[`PRS_BIT_RESTART]) begin
            state <= S_RSTRT;
          end else if (pcs_space_control[`PRS_BIT_SOFT_RESET]) begin
            state <= S_PCS;
          end else if (basic_mode_control[`PRS_BIT_SOFT_RESET]) begin
            state <= S_STD;
          end
        end
        S_STD: begin
          cnt <= cnt + 8'h01;
          basic_mode_control <= `PRS_RST_BASIC_MODE; // RQ8
          if (!act_done) begin
            basic_mode_control[`PRS_BIT_SOFT_RESET] <= 1'b1;
          end else begin
            state <= S_IDLE; // RQ15
          end
        end
        S_GLB: begin
          // Strap levels are left as they are.
          cnt <= cnt + 8'h01;
          basic_mode_control <= `PRS_RST_BASIC_MODE; // RQ9 RQ10
          indicator_mode_control <= `PRS_RST_INDICATOR;
          pcs_space_control <= `PRS_RST_PCS_CTRL;
          global_reset_control <= `PRS_RST_GLOBAL;
          if (!act_done) begin
            global_reset_control[`PRS_BIT_SOFT_RESET] <= 1'b1;
          end else begin
            state <= S_IDLE; // RQ15
          end
        end
        S_RSTRT: begin
          cnt <= cnt + 8'h01;
          if (act_done) begin
            global_reset_control[`PRS_BIT_RESTART] <= 1'b0; // RQ11 RQ15
            state <= S_IDLE;
          end
        end
        S_PCS: begin
          cnt <= cnt + 8'h01;
          pcs_space_control <= `PRS_RST_PCS_CTRL; // RQ12
          if (!act_done) begin
            pcs_space_control[`PRS_BIT_SOFT_RESET] <= 1'b1;
          end else begin
            state <= S_IDLE; // RQ15
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      // Writes come last so a fresh request in a completion cycle wins.
      if (wr_ok) begin
        if (hit_bmc) begin
          basic_mode_control <= mgmt_wdata; // RQ8
        end
        if (hit_ind) begin
          indicator_mode_control <= mgmt_wdata; // RQ1
        end
        if (hit_glb) begin
          global_reset_control <= mgmt_wdata; // RQ9 RQ11
        end
        if (hit_pcs) begin
          pcs_space_control <= mgmt_wdata; // RQ12
        end
      end
      // The cascade request is set after writes so a write cannot drop it.
      if ((state == S_PCS) && act_done) begin
        basic_mode_control[`PRS_BIT_SOFT_RESET] <= 1'b1; // RQ13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads. Unmapped offsets read as zero.

  always @(posedge mclk) begin
    if (srst) begin
      mgmt_rdata <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (!mgmt_rd) begin
        mgmt_rdata <= 16'h0000;
      end else if (hit_bmc) begin
        mgmt_rdata <= basic_mode_control;
      end else if (hit_ind) begin
        mgmt_rdata <= indicator_mode_control;
      end else if (hit_glb) begin
        mgmt_rdata <= global_reset_control;
      end else if (hit_pcs) begin
        mgmt_rdata <= pcs_space_control;
      end else begin
        mgmt_rdata <= 16'h0000; // RQ14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator drivers and reset outputs.

  always @* begin
    next_indicator = 4'h0;
    field = 4'h0;
    for (j = 0; j < 4; j = j + 1) begin
      field = indicator_mode_control[j*`PRS_IND_FIELD_W +: 4];
      next_indicator[j] = func_src[field[2:0]] &
                          ~field[`PRS_IND_OFF_BIT]; // RQ1
      // A high strap makes the driver active low.
      next_indicator[j] = next_indicator[j] ^ strap_level[j]; // RQ3 RQ4
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      indicator_out <= 4'h0;
      indicator_oe <= 4'h0;
      dev_hard_rst <= 1'b1;
      std_regs_rst <= 1'b0;
      global_rst <= 1'b0;
      restart <= 1'b0;
      pcs_space_rst <= 1'b0;
    end else begin
      indicator_out <= next_indicator;
      // Drivers stay off during hard reset and strap sampling so strap resistors are not fought.
      if ((state == S_HARD) || (state == S_STRAP) || pin_hold) begin
        indicator_oe <= 4'h0; // RQ2
      end else begin
        indicator_oe <= 4'hF;
      end
      dev_hard_rst <= (state == S_HARD) || (state == S_STRAP) || pin_hold;
      std_regs_rst <= (state == S_STD);
      global_rst <= (state == S_GLB);
      restart <= (state == S_RSTRT);
      pcs_space_rst <= (state == S_PCS);
    end
  end

endmodule // prs_reset_led

// ---- tb/prs_reset_monitor.sv ----
`timescale 1ns/1ps
`include "prs_defs.vh"
module prs_reset_monitor #(
  parameter ACTION_CYC = 8
) (
  // Clock and reset.
  input wire mclk,
  input wire srst,
  // Register writes.
  input wire mgmt_wr,
  input wire mgmt_pcs_space,
  input wire [15:0] mgmt_addr,
  input wire [15:0] mgmt_wdata,
  // Pins and reset levels.
  input wire [3:0] indicator_oe,
  input wire [3:0] strap_level,
  input wire dev_hard_rst,
  input wire std_regs_rst,
  input wire global_rst,
  input wire restart,
  input wire pcs_space_rst
);
  wire busy = dev_hard_rst | std_regs_rst | global_rst | restart
    | pcs_space_rst;
  reg quiet;
  reg [7:0] g_cnt;
  // A write is only judged after a fully idle cycle, so a pending action
  // left from an earlier request cannot be mistaken for a lost write.
  always @(posedge mclk) begin
    quiet <= !busy && !srst;
    g_cnt <= (srst || !global_rst) ? 8'h00 : g_cnt + 8'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_ctl_wr;
    mgmt_wr && !mgmt_pcs_space && mgmt_addr == `PRS_OFS_GLOBAL
      && quiet && !busy;
  endsequence
  property p_hard; $fell(srst) |-> dev_hard_rst ##1 dev_hard_rst;
  endproperty
  a_hard: assert property (p_hard) else $error("no hard reset");
  property p_oe_off; dev_hard_rst |-> indicator_oe == 4'h0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven");
  property p_oe_on; $fell(dev_hard_rst) |-> indicator_oe == 4'hF; endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  property p_keep; !dev_hard_rst && !$past(dev_hard_rst)
    |-> $stable(strap_level); endproperty
  a_keep: assert property (p_keep) else $error("strap moved");
  property p_glb; s_ctl_wr ##0 mgmt_wdata[15] |-> ##3 global_rst;
  endproperty
  a_glb: assert property (p_glb) else $error("no global reset");
  property p_rst; s_ctl_wr ##0 mgmt_wdata[15:14] == 2'b01 |-> ##3 restart;
  endproperty
  a_rst: assert property (p_rst) else $error("no restart");
  property p_len; $fell(global_rst) |-> g_cnt == ACTION_CYC; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_casc; $fell(pcs_space_rst) |-> ##[1:4] std_regs_rst;
  endproperty
  a_casc: assert property (p_casc) else $error("no cascade");
  property p_only; std_regs_rst |-> !global_rst && !pcs_space_rst;
  endproperty
  a_only: assert property (p_only) else $error("wide reset");
endmodule // prs_reset_monitor

// ---- tb/prs_strap_model.sv ----
`timescale 1ns/1ps
module prs_strap_model (
  // Resistor levels.
  input wire [3:0] strap_cfg,
  // Pin side of the block.
  input wire [3:0] indicator_out,
  input wire [3:0] indicator_oe,
  output wire [3:0] indicator_in
);
  // The resistor wins only while the block's driver is off.
  assign indicator_in = (indicator_oe & indicator_out)
    | (~indicator_oe & strap_cfg);
endmodule // prs_strap_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "prs_defs.vh"
module tb;
  reg mclk, srst, reset_n_pin, mgmt_wr, mgmt_rd, mgmt_pcs_space;
  reg [15:0] mgmt_addr, mgmt_wdata;
  reg [7:0] func_src;
  reg [3:0] cfg, lat;
  wire [15:0] mgmt_rdata;
  wire [3:0] indicator_in, indicator_out, indicator_oe, strap_level;
  wire mgmt_rvalid, dev_hard_rst, std_regs_rst, global_rst, restart;
  wire pcs_space_rst;
  integer n_std = 0, n_glb = 0, n_hard = 0, base;
  integer num_errors, total_checks, cycles = 0;
  prs_reset_led #(.STRAP_CYC(8), .ACTION_CYC(4)) i_prs_reset_led (
    .mclk(mclk), .srst(srst), .reset_n_pin(reset_n_pin),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_pcs_space(mgmt_pcs_space),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .indicator_in(indicator_in), .indicator_out(indicator_out),
    .indicator_oe(indicator_oe), .func_src(func_src),
    .dev_hard_rst(dev_hard_rst), .std_regs_rst(std_regs_rst),
    .global_rst(global_rst), .restart(restart),
    .pcs_space_rst(pcs_space_rst), .strap_level(strap_level));
  prs_strap_model i_prs_strap_model (.strap_cfg(cfg),
    .indicator_out(indicator_out), .indicator_oe(indicator_oe),
    .indicator_in(indicator_in));
  //////////////////////////////////////////////////////////////
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (std_regs_rst === 1'b1) n_std <= n_std + 1;
    if (global_rst === 1'b1) n_glb <= n_glb + 1;
    if (dev_hard_rst === 1'b1) n_hard <= n_hard + 1;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [15:0] seen, input [15:0] exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr(input sp, input [15:0] a, input [15:0] d);
    @(posedge mclk); #1;
    mgmt_wr = 1'b1; mgmt_pcs_space = sp; mgmt_addr = a; mgmt_wdata = d;
    @(posedge mclk); #1;
    mgmt_wr = 1'b0;
  endtask
  task rd(input sp, input [15:0] a, input [15:0] e, input string w);
    @(posedge mclk); #1;
    mgmt_rd = 1'b1; mgmt_pcs_space = sp; mgmt_addr = a;
    @(posedge mclk); #1;
    mgmt_rd = 1'b0;
    chk({15'h0000, mgmt_rvalid}, 16'h0001, "rvalid");
    chk(mgmt_rdata, e, w);
  endtask
  // The block holds straps for a few cycles after release, so wait here.
  task up;
    integer k;
    k = 0;
    while (dev_hard_rst !== 1'b0 && k < 100) begin
      @(posedge mclk);
      k = k + 1;
    end
    cyc(1);
  endtask
  task led(input [15:0] m, input [7:0] s);
    integer i;
    reg [3:0] e;
    wr(1'b0, `PRS_OFS_INDICATOR, m);
    func_src = s;
    cyc(3);
    for (i = 0; i < 4; i = i + 1) e[i] = (s[m[4*i+:3]] & ~m[4*i+3]) ^ lat[i];
    chk({12'h000, indicator_out}, {12'h000, e}, "indicator");
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    mclk = 0; srst = 1; reset_n_pin = 1; mgmt_wr = 0; mgmt_rd = 0;
    mgmt_pcs_space = 0; mgmt_addr = 0; mgmt_wdata = 0; func_src = 0;
    cfg = 4'h5; lat = 4'h5; num_errors = 0; total_checks = 0; base = 0;
    cyc(5); srst = 0; up;
    chk({12'h000, strap_level}, 16'h0005, "strap");
    rd(0, 16'h0000, `PRS_RST_BASIC_MODE, "basic");
    rd(0, 16'h0018, `PRS_RST_INDICATOR, "ind");
    rd(0, 16'h001F, `PRS_RST_GLOBAL, "global");
    rd(1, 16'h1000, `PRS_RST_PCS_CTRL, "pcs");
    rd(0, 16'h0005, 16'h0000, "unmapped");
    led(16'h8888, 8'hFF);
    led(16'h0000, 8'hFF);
    led(16'h7531, 8'hA6);
    led(16'h0246, 8'h5B);
    cfg = 4'hA; base = n_glb;
    wr(0, 16'h001F, 16'h8000);
    rd(0, 16'h001F, 16'h8000, "glb busy");
    cyc(12);
    rd(0, 16'h001F, 16'h0000, "glb done");
    rd(0, 16'h0018, `PRS_RST_INDICATOR, "ind glb");
    chk({15'h0000, (n_glb > base)}, 16'h0001, "glb seen");
    chk({12'h000, strap_level}, 16'h0005, "strap glb");
    wr(0, 16'h0018, 16'h1234);
    wr(0, 16'h001F, 16'h4000);
    cyc(12);
    rd(0, 16'h0018, 16'h1234, "ind rst");
    rd(0, 16'h001F, 16'h0000, "rst done");
    base = n_std;
    wr(0, 16'h0000, 16'h8000);
    cyc(12);
    rd(0, 16'h0000, `PRS_RST_BASIC_MODE, "std done");
    rd(0, 16'h0018, 16'h1234, "ind std");
    chk({15'h0000, (n_std > base)}, 16'h0001, "std seen");
    base = n_std;
    wr(1, 16'h1000, 16'h8000);
    cyc(20);
    rd(1, 16'h1000, `PRS_RST_PCS_CTRL, "pcs done");
    rd(0, 16'h0000, `PRS_RST_BASIC_MODE, "casc");
    chk({15'h0000, (n_std > base)}, 16'h0001, "casc seen");
    base = n_hard;
    reset_n_pin = 0;
    cyc(50);
    reset_n_pin = 1;
    cyc(10);
    chk({15'h0000, (n_hard != base)}, 16'h0000, "short pin");
    reset_n_pin = 0;
    cyc(220);
    reset_n_pin = 1;
    cyc(8); up; lat = 4'hA;
    chk({12'h000, strap_level}, 16'h000A, "strap pin");
    rd(0, 16'h0018, `PRS_RST_INDICATOR, "ind pin");
    led(16'h0000, 8'hFF);
    end_of_test;
  end
endmodule // tb
bind prs_reset_led prs_reset_monitor #(.ACTION_CYC(ACTION_CYC))
  i_prs_reset_monitor (.mclk(mclk), .srst(srst), .mgmt_wr(mgmt_wr),
  .mgmt_pcs_space(mgmt_pcs_space), .mgmt_addr(mgmt_addr),
  .mgmt_wdata(mgmt_wdata), .indicator_oe(indicator_oe),
  .strap_level(strap_level), .dev_hard_rst(dev_hard_rst),
  .std_regs_rst(std_regs_rst), .global_rst(global_rst),
  .restart(restart), .pcs_space_rst(pcs_space_rst));
